// ==== hw/rtc_pkg.sv ====
// Purpose: constants for the seconds and wake-up real-time clock
// Assumes: 25 MHz pclk, APB register access
// Notes:   tick rates are derived from the clock rate
package rtc_pkg;
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned SEC_HZ         = 1;
  localparam int unsigned MS_HZ          = 1_000;
  localparam int unsigned SUB_HZ         = 32_768;
  localparam int unsigned SEC_DIV        = CLK_HZ / SEC_HZ;
  localparam int unsigned MS_DIV         = CLK_HZ / MS_HZ;
  localparam int unsigned SUB_DIV        = CLK_HZ / SUB_HZ;
  localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
  localparam logic [7:0]  MATCH_OFFSET   = 8'h04;
  localparam logic [7:0]  COUNT_OFFSET   = 8'h08;
  localparam logic [7:0]  WAKE_OFFSET    = 8'h0c;
  localparam logic [7:0]  SUBSECOND_COUNT_OFFSET  = 8'h10;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h14;
  localparam int unsigned CTRL_SWRESET   = 0;
  localparam int unsigned CTRL_MASTER    = 1;
  localparam int unsigned CTRL_WAKE_EN   = 2;
  localparam int unsigned CTRL_SUB_EN    = 3;
  localparam int unsigned CTRL_ALARM_DPD = 4;
  localparam int unsigned CTRL_WAKE_DPD  = 5;
  localparam int unsigned FLAG_ALARM     = 0;
  localparam int unsigned FLAG_WAKE      = 1;
  localparam logic [5:0]  CTRL_RESET     = 6'h00;
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
  localparam logic [15:0] WAKE_RESET     = 16'h0000;
endpackage : rtc_pkg

// ==== hw/seconds_wakeup_rtc.sv ====
// Purpose: seconds counter, millisecond wake-up countdown, sub-second counter
// Assumes: APB slave, zero wait states, pslverr for unmapped addresses
// Notes:   all ticks are prescaled from pclk
`timescale 1ns/10ps
`default_nettype none

// Contract
// - seconds counter advances once per second while master enable is set
// - wake countdown decrements each millisecond when wake and master enables set
// - master enable gates all three timers; countdown never runs without it
// - seconds counter writes ignored while counter runs
// - sub-second counter at 32 kHz readable from its own register
// - separate enable lets wake interrupt leave deep power down
// - separate enable lets alarm interrupt leave deep power down
// - status flags readable and cleared by write-one mask
// - with wake enable clear only seconds timer and, if its enable is set, sub-second counter run
// - two flags, seconds alarm and millisecond wake-up
// - software reset bit resets timer registers and stays until cleared
module seconds_wakeup_rtc
  import rtc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_DIV,
  parameter int unsigned MS_CYCLES  = MS_DIV,
  parameter int unsigned SUB_CYCLES = SUB_DIV
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // wake requests
  output var  logic        alarm_wake_req,
  output var  logic        wake_timer_req
);

  // prescalers need a terminal count above zero
  if (SEC_CYCLES < 2) begin : g_sec_cycles_bad
    $error("seconds prescale count must be at least 2");
  end
  if (MS_CYCLES < 2) begin : g_ms_cycles_bad
    $error("millisecond prescale count must be at least 2");
  end
  if (SUB_CYCLES < 2) begin : g_sub_cycles_bad
    $error("sub-second prescale count must be at least 2");
  end

  logic [5:0]  ctrl;
  logic [31:0] match_value;
  logic [31:0] seconds;
  logic [15:0] wake_count;
  logic [31:0] subsecond_count;
  logic [1:0]  flags;
  logic [31:0] sec_pre;
  logic [31:0] ms_pre;
  logic [31:0] sub_pre;
  logic [5:0]  next_ctrl;
  logic [31:0] next_match_value;
  logic [31:0] next_seconds;
  logic [15:0] next_wake_count;
  logic [31:0] next_subsecond_count;
  logic [1:0]  next_flags;
  logic [31:0] next_sec_pre;
  logic [31:0] next_ms_pre;
  logic [31:0] next_sub_pre;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        next_alarm_wake_req;
  logic        next_wake_timer_req;

  logic timer_master_enable;
  logic wake_run;
  logic sub_run;
  logic sec_tick;
  logic ms_tick;
  logic sub_tick;
  logic setup;
  logic wr;
  logic mapped;
  logic [1:0] flag_set;
  logic wr_ctrl;
  logic wr_match;
  logic wr_count;
  logic wr_wake;
  logic wr_status;
  logic swreset_hold;
  logic alarm_hit;
  logic wake_hit;

  always_comb begin
    timer_master_enable = ctrl[CTRL_MASTER] && !ctrl[CTRL_SWRESET];
    wake_run = timer_master_enable && ctrl[CTRL_WAKE_EN];
    sub_run  = timer_master_enable && ctrl[CTRL_SUB_EN];
    sec_tick = timer_master_enable && (sec_pre == SEC_CYCLES - 1);
    ms_tick  = wake_run && (ms_pre == MS_CYCLES - 1);
    sub_tick = sub_run && (sub_pre == SUB_CYCLES - 1);
    setup  = psel && !penable;
    wr     = psel && penable && pwrite;
    mapped = (paddr == CTRL_OFFSET) || (paddr == MATCH_OFFSET) ||
             (paddr == COUNT_OFFSET) || (paddr == WAKE_OFFSET) ||
             (paddr == SUBSECOND_COUNT_OFFSET) || (paddr == STATUS_OFFSET);
    wr_ctrl      = wr && (paddr == CTRL_OFFSET);
    wr_match     = wr && (paddr == MATCH_OFFSET);
    wr_count     = wr && (paddr == COUNT_OFFSET);
    wr_wake      = wr && (paddr == WAKE_OFFSET);
    wr_status    = wr && (paddr == STATUS_OFFSET);
    swreset_hold = ctrl[CTRL_SWRESET] && !wr_ctrl;
    alarm_hit    = sec_tick && (seconds + 32'h0000_0001 == match_value);
    wake_hit     = ms_tick && (wake_count == 16'h0001);
  end

  always_comb begin
    next_ctrl        = ctrl;
    next_match_value = match_value;
    if (wr_ctrl) begin
      next_ctrl = pwdata[5:0];
    end
    if (wr_match) begin
      next_match_value = pwdata;
    end
    if (swreset_hold) begin
      next_match_value = WORD_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl        <= CTRL_RESET;
      match_value <= WORD_RESET;
    end else begin
      ctrl        <= next_ctrl;
      match_value <= next_match_value;
    end
  end

  always_comb begin
    next_seconds = seconds;
    next_sec_pre = WORD_RESET;
    if (timer_master_enable) begin
      next_sec_pre = sec_tick ? WORD_RESET : sec_pre + 32'h0000_0001;
      if (sec_tick) begin
        next_seconds = seconds + 32'h0000_0001;
      end
    end
    if (wr_count && !timer_master_enable) begin
      next_seconds = pwdata;
    end
    if (swreset_hold) begin
      next_seconds = WORD_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seconds <= WORD_RESET;
      sec_pre <= WORD_RESET;
    end else begin
      seconds <= next_seconds;
      sec_pre <= next_sec_pre;
    end
  end

  always_comb begin
    next_wake_count = wake_count;
    next_ms_pre     = WORD_RESET;
    if (wake_run && wake_count != WAKE_RESET) begin
      next_ms_pre = ms_tick ? WORD_RESET : ms_pre + 32'h0000_0001;
      if (ms_tick) begin
        next_wake_count = wake_count - 16'h0001;
      end
    end
    if (wr_wake) begin
      next_wake_count = pwdata[15:0];
      next_ms_pre     = WORD_RESET;
    end
    if (swreset_hold) begin
      next_wake_count = WAKE_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_count <= WAKE_RESET;
      ms_pre     <= WORD_RESET;
    end else begin
      wake_count <= next_wake_count;
      ms_pre     <= next_ms_pre;
    end
  end

  always_comb begin
    next_subsecond_count = subsecond_count;
    next_sub_pre         = WORD_RESET;
    if (sub_run) begin
      next_sub_pre = sub_tick ? WORD_RESET : sub_pre + 32'h0000_0001;
      if (sub_tick) begin
        next_subsecond_count = subsecond_count + 32'h0000_0001;
      end
    end
    if (swreset_hold) begin
      next_subsecond_count = WORD_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subsecond_count <= WORD_RESET;
      sub_pre         <= WORD_RESET;
    end else begin
      subsecond_count <= next_subsecond_count;
      sub_pre         <= next_sub_pre;
    end
  end

  always_comb begin
    flag_set             = 2'h0;
    flag_set[FLAG_ALARM] = alarm_hit;
    flag_set[FLAG_WAKE]  = wake_hit;
    next_flags           = flags;
    if (wr_status) begin
      next_flags = flags & ~pwdata[1:0];
    end
    next_flags = next_flags | flag_set;
    if (swreset_hold) begin
      next_flags = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 2'h0;
    end else begin
      flags <= next_flags;
    end
  end

  always_comb begin
    next_prdata  = WORD_RESET;
    next_pready  = setup;
    next_pslverr = setup && !mapped;
    if (setup && !pwrite) begin
      case (paddr)
        CTRL_OFFSET: begin
          next_prdata = {26'h000_0000, ctrl};
        end
        MATCH_OFFSET: begin
          next_prdata = match_value;
        end
        COUNT_OFFSET: begin
          next_prdata = seconds;
        end
        WAKE_OFFSET: begin
          next_prdata = {16'h0000, wake_count};
        end
        SUBSECOND_COUNT_OFFSET: begin
          next_prdata = subsecond_count;
        end
        STATUS_OFFSET: begin
          next_prdata = {30'h0000_0000, flags};
        end
        default: begin
          next_prdata = WORD_RESET;
        end
      endcase
    end
    next_alarm_wake_req = next_flags[FLAG_ALARM] && next_ctrl[CTRL_ALARM_DPD];
    next_wake_timer_req = next_flags[FLAG_WAKE] && next_ctrl[CTRL_WAKE_DPD];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata         <= WORD_RESET;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      alarm_wake_req <= 1'b0;
      wake_timer_req <= 1'b0;
    end else begin
      prdata         <= next_prdata;
      pready         <= next_pready;
      pslverr        <= next_pslverr;
      alarm_wake_req <= next_alarm_wake_req;
      wake_timer_req <= next_wake_timer_req;
    end
  end

endmodule : seconds_wakeup_rtc

`default_nettype wire

// ==== verification/seconds_wakeup_rtc_monitor.sv ====
// Purpose: port checks for the rtc block
// Assumes: one clock, async low reset
// Notes:   bound from the testbench top
`timescale 1ns/10ps
`default_nettype none
module seconds_wakeup_rtc_monitor
  import rtc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_DIV,
  parameter int unsigned MS_CYCLES  = MS_DIV,
  parameter int unsigned SUB_CYCLES = SUB_DIV
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        alarm_wake_req,
  input wire logic        wake_timer_req
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ctrl;
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == CTRL_OFFSET;
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  chk_err_unmapped: assert property (psel && !penable && paddr > 8'h14 |=> pslverr)
    else $error("no error on unmapped address");
  chk_err_mapped: assert property (psel && !penable && paddr[1:0] == 2'h0
    && paddr <= 8'h14 |=> pready && !pslverr) else $error("mapped access refused");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access");
  chk_alarm_gate: assert property (wr_ctrl && !pwdata[4] |-> ##2 !alarm_wake_req)
    else $error("alarm request while disabled");
  chk_wake_gate: assert property (wr_ctrl && !pwdata[5] |-> ##2 !wake_timer_req)
    else $error("wake request while disabled");
  chk_swreset_clear: assert property (wr_ctrl && pwdata[0] |-> ##2
    !alarm_wake_req && !wake_timer_req) else $error("request kept in reset");
  cover property (alarm_wake_req);
  cover property (wake_timer_req);
  cover property (pslverr);
endmodule : seconds_wakeup_rtc_monitor
`default_nettype wire

// ==== verification/seconds_wakeup_rtc_tb.sv ====
// Purpose: register level test of the rtc block
// Assumes: shortened prescalers 20, 5, 3
// Notes:   apb master tasks, bounded waits
`timescale 1ns/10ps
`default_nettype none
module seconds_wakeup_rtc_tb;
  import rtc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        alarm_wake_req, wake_timer_req;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, first_rd;
  int          error_cnt, tests_run, n_try;
  seconds_wakeup_rtc #(.SEC_CYCLES(20), .MS_CYCLES(5), .SUB_CYCLES(3)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alarm_wake_req(alarm_wake_req), .wake_timer_req(wake_timer_req));
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err = 1'b0);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 10);
    if (pready !== 1'b1) begin
      error_cnt++;
      final_report();
    end else begin
      rd = prdata;
      chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 24; a += 4) rdchk(8'(a), 32'h0, "reset value");
    apb(1'b0, 8'h18, 32'h0, 1'b1);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, COUNT_OFFSET, 32'h5);
    apb(1'b1, MATCH_OFFSET, 32'h7);
    apb(1'b1, CTRL_OFFSET, 32'h2);
    apb(1'b1, COUNT_OFFSET, 32'h64);
    repeat (44) @(posedge pclk);
    rdchk(COUNT_OFFSET, 32'h7, "seconds");
    rdchk(STATUS_OFFSET, 32'h1, "alarm flag");
    chk("alarm req off", 32'h0, {31'h0, alarm_wake_req});
    apb(1'b1, CTRL_OFFSET, 32'h10);
    repeat (2) @(posedge pclk);
    chk("alarm req on", 32'h1, {31'h0, alarm_wake_req});
    apb(1'b1, STATUS_OFFSET, 32'h1);
    rdchk(STATUS_OFFSET, 32'h0, "flag cleared");
    chk("alarm req cleared", 32'h0, {31'h0, alarm_wake_req});
    apb(1'b1, WAKE_OFFSET, 32'h3);
    apb(1'b1, CTRL_OFFSET, 32'h4);
    repeat (30) @(posedge pclk);
    rdchk(WAKE_OFFSET, 32'h3, "no master");
    apb(1'b1, CTRL_OFFSET, 32'h2);
    repeat (30) @(posedge pclk);
    rdchk(WAKE_OFFSET, 32'h3, "no wake enable");
    apb(1'b1, CTRL_OFFSET, 32'h26);
    n_try = 0;
    do begin
      apb(1'b0, WAKE_OFFSET, 32'h0);
      first_rd = rd;
      apb(1'b0, WAKE_OFFSET, 32'h0);
      n_try++;
    end while (rd !== first_rd && n_try < 4);
    chk("wake double read", first_rd, rd);
    repeat (30) @(posedge pclk);
    rdchk(WAKE_OFFSET, 32'h0, "countdown");
    chk("wake req", 32'h1, {31'h0, wake_timer_req});
    rdchk(STATUS_OFFSET, 32'h2, "wake flag");
    apb(1'b1, CTRL_OFFSET, 32'ha);
    repeat (30) @(posedge pclk);
    apb(1'b0, SUBSECOND_COUNT_OFFSET, 32'h0);
    chk("subsecond_count", 32'h1, {31'h0, rd >= 32'h8 && rd <= 32'hc});
    apb(1'b1, CTRL_OFFSET, 32'h1);
    rdchk(MATCH_OFFSET, 32'h0, "match reset");
    rdchk(CTRL_OFFSET, 32'h1, "reset bit held");
    final_report();
  end
endmodule : seconds_wakeup_rtc_tb
bind seconds_wakeup_rtc seconds_wakeup_rtc_monitor #(.SEC_CYCLES(SEC_CYCLES),
  .MS_CYCLES(MS_CYCLES), .SUB_CYCLES(SUB_CYCLES)) mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_wake_req(alarm_wake_req),
  .wake_timer_req(wake_timer_req));
`default_nettype wire
